// ### hdl/tachometer_measure_postproc.sv
`timescale 1ns/1ns
`include "tach_consts.svh"
module tachometer_measure_postproc #(
   parameter int W             = 16,
   parameter int IN_W          = 2,
   parameter int SAMPLE_CYCLES = `SAMPLE_MS * `CLK_KHZ,
   parameter int TENTH_CYCLES  = `TENTH_MS * `CLK_KHZ
)
(
   input  wire logic            clk_i,
   input  wire logic            rst_i,
   input  wire logic [7:0]      wb_adr_i,
   input  wire logic [31:0]     wb_dat_i,
   input  wire logic [3:0]      wb_sel_i,
   input  wire logic            wb_we_i,
   input  wire logic            wb_cyc_i,
   input  wire logic            wb_stb_i,
   output logic      [31:0]     wb_dat_o,
   output logic                 wb_ack_o,
   input  wire logic [IN_W-1:0] inputs_i,
   input  wire logic [W-1:0]    freq_i,
   input  wire logic            stage_one_i,
   input  wire logic            stage_two_i,
   input  wire logic            key_protect_sw_i,
   input  wire logic [3:0]      keys_i,
   output logic      [3:0]      keys_o,
   output logic                 key_protect_led_o,
   output logic      [W-1:0]    measure_o,
   output logic                 measure_update_o,
   output logic                 colour_red_o,
   output logic                 colour_green_o,
   output logic                 transistor_o,
   output logic                 contact_o
);
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [`CTRL_W-1:0]   ctrl_q;
   logic [`CTRL_W-1:0]   ctrl_d;
   logic [`TENTHS_W-1:0] zero_q;
   logic [`TENTHS_W-1:0] zero_d;
   logic [`TENTHS_W-1:0] start_q;
   logic [`TENTHS_W-1:0] start_d;
   logic [31:0]          wmask;
   logic [31:0]          rdata;
   logic                 bus_req;
   logic                 bus_wr;
   logic                 sel_ctrl;
   logic                 sel_zero;
   logic                 sel_start;
   logic                 sel_status;

   // ----------------------------------------------------------------
   // Decoded settings
   // ----------------------------------------------------------------
   tach_pkg::avg_sel_t    avg_sel;
   tach_pkg::colour_sel_t colour_sel;
   tach_pkg::out_mode_t   out_mode;
   logic                  alloc;
   logic                  polarity;
   logic [2:0]            kp_level;
   logic                  avg_changed;

   // ----------------------------------------------------------------
   // Timers and measurement state
   // ----------------------------------------------------------------
   tach_pkg::run_state_t  state_q;
   logic [31:0]           sample_cnt_q;
   logic                  sample_tick;
   logic [31:0]           start_cyc_q;
   logic                  start_tenth;
   logic [`TENTHS_W-1:0]  start_tenths_q;
   logic                  start_done;
   logic [31:0]           zero_cyc_q;
   logic                  zero_tenth;
   logic [`TENTHS_W-1:0]  zero_tenths_q;
   logic [`TENTHS_W-1:0]  zero_limit;
   logic                  zero_forced;
   logic [IN_W-1:0]       ext_in;
   logic                  pulse_q;
   logic                  pulse_edge;
   logic [W-1:0]          result_q;
   logic                  running;

   // ----------------------------------------------------------------
   // Output logic
   // ----------------------------------------------------------------
   logic                  out_one;
   logic                  out_two;
   logic                  any_on;
   logic                  red_d;
   logic [3:0]            allow;

   avg_if #(.W(W)) av ();

   sample_averager #(.W(W)) u_avg (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .a     (av)
   );

   // ----------------------------------------------------------------
   // Wishbone slave
   // ----------------------------------------------------------------
   assign bus_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign bus_wr     = bus_req && wb_we_i;
   assign sel_ctrl   = (wb_adr_i == `ADDR_CTRL);
   assign sel_zero   = (wb_adr_i == `ADDR_ZERO);
   assign sel_start  = (wb_adr_i == `ADDR_START);
   assign sel_status = (wb_adr_i == `ADDR_STATUS);

   genvar b;
   generate
      for (b = 0; b < 4; b++)
      begin : g_mask
         assign wmask[8*b +: 8] = {8{wb_sel_i[b]}};
      end
   endgenerate

   assign ctrl_d  = (ctrl_q & ~wmask[`CTRL_W-1:0]) | (wb_dat_i[`CTRL_W-1:0] & wmask[`CTRL_W-1:0]);
   assign zero_d  = (zero_q & ~wmask[`TENTHS_W-1:0]) | (wb_dat_i[`TENTHS_W-1:0] & wmask[`TENTHS_W-1:0]);
   assign start_d = (start_q & ~wmask[`TENTHS_W-1:0]) | (wb_dat_i[`TENTHS_W-1:0] & wmask[`TENTHS_W-1:0]);

   // Out-of-range settings are clamped on write so the timers never see them.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_q  <= `CTRL_RST;
         zero_q  <= `ZERO_RST;
         start_q <= `START_RST;
      end
      else if (bus_wr)
      begin
         if (sel_ctrl)
            ctrl_q <= ctrl_d;
         if (sel_zero)
            zero_q <= (zero_d < `TENTHS_MIN) ? `TENTHS_MIN : (zero_d > `TENTHS_MAX) ? `TENTHS_MAX : zero_d;
         if (sel_start)
            start_q <= (start_d > `TENTHS_MAX) ? `TENTHS_MAX : start_d;
      end
   end

   always_comb
   begin
      rdata = 32'h0000_0000;
      if (sel_ctrl)
         rdata[`CTRL_W-1:0] = ctrl_q;
      if (sel_zero)
         rdata[`TENTHS_W-1:0] = zero_q;
      if (sel_start)
         rdata[`TENTHS_W-1:0] = start_q;
      if (sel_status)
      begin
         rdata[W-1:0]     = measure_o;
         rdata[`ST_ZERO]  = zero_forced;
         rdata[`ST_BUSY]  = !running;
         rdata[`ST_KPSW]  = key_protect_sw_i;
         rdata[`ST_PULSE] = pulse_q;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_req ? rdata : 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // Settings
   // ----------------------------------------------------------------
   assign avg_sel     = tach_pkg::avg_sel_t'(ctrl_q[`CTRL_AVG]);
   assign colour_sel  = tach_pkg::colour_sel_t'(ctrl_q[`CTRL_COLOUR]);
   assign out_mode    = tach_pkg::out_mode_t'(ctrl_q[`CTRL_MODE]);
   assign alloc       = ctrl_q[`CTRL_ALLOC];
   assign polarity    = ctrl_q[`CTRL_POL];
   assign kp_level    = ctrl_q[`CTRL_KPL];
   assign avg_changed = bus_wr && sel_ctrl && (ctrl_d[`CTRL_AVG] != ctrl_q[`CTRL_AVG]);

   // One polarity bit flips every external input the same way.
   assign ext_in     = inputs_i ^ {IN_W{polarity}};
   assign pulse_edge = ext_in[0] && !pulse_q;

   // ----------------------------------------------------------------
   // Startup inhibit
   // ----------------------------------------------------------------
   assign start_tenth = (start_cyc_q == 32'(TENTH_CYCLES - 1));
   assign start_done  = (start_tenths_q >= start_q);
   assign running     = (state_q == tach_pkg::ST_RUN);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_q        <= tach_pkg::ST_STARTUP;
         start_cyc_q    <= 32'h0000_0000;
         start_tenths_q <= `START_RST;
      end
      else
      begin
         start_cyc_q <= start_tenth ? 32'h0000_0000 : start_cyc_q + 32'h0000_0001;
         if (start_tenth && start_tenths_q < `TENTHS_MAX)
            start_tenths_q <= start_tenths_q + 10'h001;
         // A longer startup time written while the count is still below it takes effect at once.
         case (state_q)
            tach_pkg::ST_STARTUP:
               if (start_done)
                  state_q <= tach_pkg::ST_RUN;
            tach_pkg::ST_RUN:
               if (!start_done)
                  state_q <= tach_pkg::ST_STARTUP;
            default:
               state_q <= tach_pkg::ST_STARTUP;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Sampling and auto-zero
   // ----------------------------------------------------------------
   assign sample_tick = running && (sample_cnt_q == 32'(SAMPLE_CYCLES - 1));
   assign zero_tenth  = (zero_cyc_q == 32'(TENTH_CYCLES - 1));
   assign zero_limit  = zero_q;

   assign av.sample       = freq_i;
   assign av.sample_valid = sample_tick;
   assign av.shift        = ctrl_q[`CTRL_AVG];
   assign av.clear        = avg_changed || !running;

   // The idle count saturates at the limit, so a stopped shaft cannot wrap it.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sample_cnt_q  <= 32'h0000_0000;
         zero_cyc_q    <= 32'h0000_0000;
         zero_tenths_q <= 10'h000;
         zero_forced   <= 1'b0;
         pulse_q       <= 1'b0;
         result_q      <= '0;
      end
      else
      begin
         pulse_q <= ext_in[0];
         if (!running || sample_tick)
            sample_cnt_q <= 32'h0000_0000;
         else
            sample_cnt_q <= sample_cnt_q + 32'h0000_0001;
         if (pulse_edge || !running)
         begin
            zero_cyc_q    <= 32'h0000_0000;
            zero_tenths_q <= 10'h000;
            zero_forced   <= 1'b0;
         end
         else
         begin
            zero_cyc_q <= zero_tenth ? 32'h0000_0000 : zero_cyc_q + 32'h0000_0001;
            if (zero_tenth && zero_tenths_q < zero_limit)
               zero_tenths_q <= zero_tenths_q + 10'h001;
            zero_forced <= (zero_tenths_q >= zero_limit);
         end
         if (av.mean_valid)
            result_q <= av.mean;
      end
   end

   // ----------------------------------------------------------------
   // Control outputs, colour and keys
   // ----------------------------------------------------------------
   assign out_one = running && stage_one_i;
   assign out_two = running && stage_two_i;
   assign any_on  = (out_mode == tach_pkg::MODE_AREA) ? out_one : (out_one || out_two);

   always_comb
   begin
      case (colour_sel)
         tach_pkg::COL_RED:   red_d = 1'b1;
         tach_pkg::COL_GREEN: red_d = 1'b0;
         tach_pkg::COL_R2G:   red_d = !any_on;
         tach_pkg::COL_G2R:   red_d = any_on;
         default:             red_d = 1'b1;
      endcase
   end

   // Unused level codes fall back to the strictest level, the safe side.
   always_comb
   begin
      allow = `KEY_ALL;
      if (key_protect_sw_i)
      begin
         case (kp_level)
            `KP_ONE:   allow = 4'b1110;
            `KP_TWO:   allow = 4'b1010;
            `KP_THREE: allow = 4'b0110;
            `KP_FOUR:  allow = 4'b0010;
            default:   allow = 4'b0000;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         transistor_o      <= 1'b0;
         contact_o         <= 1'b0;
         colour_red_o      <= 1'b0;
         colour_green_o    <= 1'b0;
         keys_o            <= 4'h0;
         key_protect_led_o <= 1'b0;
         measure_o         <= '0;
         measure_update_o  <= 1'b0;
      end
      else
      begin
         transistor_o      <= alloc ? out_two : out_one;
         contact_o         <= alloc ? out_one : out_two;
         colour_red_o      <= red_d;
         colour_green_o    <= !red_d;
         keys_o            <= keys_i & allow;
         key_protect_led_o <= key_protect_sw_i;
         measure_o         <= (zero_forced || !running) ? '0 : result_q;
         measure_update_o  <= av.mean_valid;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_kp_indicator: assert property (!rst_i |=> key_protect_led_o == $past(key_protect_sw_i))
      else $error("Protect indicator does not follow switch.");
   a_mode_key_blocked: assert property (key_protect_sw_i |=> !keys_o[`KEY_MODE])
      else $error("Mode key passed while protected.");
   a_level_five_all: assert property (key_protect_sw_i && kp_level == 3'h5 |=> keys_o == 4'h0)
      else $error("Level five let a key through.");
   a_keys_free: assert property (!rst_i && !key_protect_sw_i |=> keys_o == $past(keys_i))
      else $error("Key blocked with protect off.");
   a_alloc_swap: assert property (running && alloc && stage_one_i |=> contact_o)
      else $error("Stage one not on contact output when swapped.");
   a_startup_quiet: assert property (!running |=> !transistor_o && !contact_o && measure_o == '0)
      else $error("Output active during startup.");
   a_zero_forced: assert property (zero_forced |=> measure_o == '0)
      else $error("Display not zero after timeout.");
   a_pulse_restart: assert property (running && pulse_edge |=> zero_tenths_q == 10'h000 && !zero_forced)
      else $error("Pulse did not restart timeout.");
   a_area_colour: assert property (running && colour_sel == tach_pkg::COL_R2G && out_mode == tach_pkg::MODE_AREA
                                   && !stage_one_i && stage_two_i |=> colour_red_o)
      else $error("Band window colour used output two.");
   a_fixed_green: assert property (colour_sel == tach_pkg::COL_GREEN |=> colour_green_o && !colour_red_o)
      else $error("Fixed green not shown.");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("Acknowledge held too long.");
endmodule

// ### hdl/tach_consts.svh
`ifndef TACH_CONSTS_SVH
`define TACH_CONSTS_SVH
// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define ADDR_CTRL       8'h00
`define ADDR_ZERO       8'h04
`define ADDR_START      8'h08
`define ADDR_STATUS     8'h0c
// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define CTRL_AVG        1:0
`define CTRL_COLOUR     3:2
`define CTRL_MODE       5:4
`define CTRL_ALLOC      6
`define CTRL_POL        7
`define CTRL_KPL        10:8
`define CTRL_W          11
`define CTRL_RST        11'h100
// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define ST_ZERO         16
`define ST_BUSY         17
`define ST_KPSW         18
`define ST_PULSE        19
// ----------------------------------------------------------------
// Settings in tenths of a second
// ----------------------------------------------------------------
`define TENTHS_W        10
`define TENTHS_MIN      10'h001
`define TENTHS_MAX      10'h3e7
`define ZERO_RST        10'h00a
`define START_RST       10'h000
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_KHZ         100000
`define SAMPLE_MS       200
`define TENTH_MS        100
// ----------------------------------------------------------------
// Key bits and protect levels
// ----------------------------------------------------------------
`define KEY_MODE        0
`define KEY_DISP        1
`define KEY_RESET       2
`define KEY_DIGIT       3
`define KEY_ALL         4'hf
`define KP_ONE          3'h1
`define KP_TWO          3'h2
`define KP_THREE        3'h3
`define KP_FOUR         3'h4
`endif

// ### hdl/tach_pkg.sv
package tach_pkg;
   typedef enum logic [1:0] {AVG_NONE, AVG_TWO, AVG_FOUR, AVG_EIGHT} avg_sel_t;
   typedef enum logic [1:0] {COL_RED, COL_GREEN, COL_R2G, COL_G2R} colour_sel_t;
   typedef enum logic [1:0] {MODE_HILO, MODE_AREA, MODE_HIHI, MODE_LOLO} out_mode_t;
   typedef enum {ST_STARTUP, ST_RUN} run_state_t;
endpackage

// ### hdl/avg_if.sv
`timescale 1ns/1ns
interface avg_if #(parameter int W = 16);
   logic [W-1:0] sample;
   logic         sample_valid;
   logic [1:0]   shift;
   logic         clear;
   logic [W-1:0] mean;
   logic         mean_valid;
   modport ctrl (output sample, sample_valid, shift, clear, input mean, mean_valid);
   modport avg  (input sample, sample_valid, shift, clear, output mean, mean_valid);
endinterface

// ### hdl/sample_averager.sv
`timescale 1ns/1ns
`include "tach_consts.svh"
module sample_averager #(parameter int W = 16)
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   avg_if.avg        a
);
   logic [W+2:0] sum_q;
   logic [W+2:0] sum_d;
   logic [3:0]   n_q;
   logic [3:0]   n_next;
   logic [3:0]   n_target;
   logic         full;
   logic [W+2:0] mean_full;
   logic [W-1:0] mean_q;
   logic         valid_q;

   // ----------------------------------------------------------------
   // Accumulate a power-of-two number of samples
   // ----------------------------------------------------------------
   assign sum_d     = sum_q + (W+3)'(a.sample);
   assign n_next    = n_q + 4'h1;
   assign n_target  = 4'h1 << a.shift;
   assign full      = (n_next == n_target);
   assign mean_full = sum_d >> a.shift;
   assign a.mean       = mean_q;
   assign a.mean_valid = valid_q;

   always_ff @(posedge clk_i)
   begin
      valid_q <= 1'b0;
      if (rst_i || a.clear)
      begin
         sum_q <= '0;
         n_q   <= 4'h0;
      end
      else if (a.sample_valid && full)
      begin
         mean_q  <= mean_full[W-1:0];
         valid_q <= 1'b1;
         sum_q   <= '0;
         n_q     <= 4'h0;
      end
      else if (a.sample_valid)
      begin
         sum_q <= sum_d;
         n_q   <= n_next;
      end
      if (rst_i)
         mean_q <= '0;
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_clear_history: assert property (a.clear |=> n_q == 4'h0 && sum_q == '0)
      else $error("History not cleared.");
   a_mean_count: assert property (a.sample_valid && !a.clear && a.shift == 2'h0 |=> valid_q)
      else $error("Single sample did not yield a result.");
endmodule

// ### tb/pulse_sensor_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Pulse sensor with a settable rate reading
// ----------------------------------------------------------------
module pulse_sensor_model
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        run_i,
   input  wire logic [15:0] rate_i,
   output logic             pulse_o,
   output logic [15:0]      freq_o
);
   logic [2:0] phase_q;
   logic [2:0] phase_d;
   // A stopped shaft leaves the line low, so every rising edge is a real pulse.
   assign phase_d = (rst_i || !run_i) ? 3'h0 : phase_q + 3'h1;
   assign pulse_o = run_i && (phase_q[2:1] == 2'h3);
   assign freq_o  = rate_i;
   always_ff @(posedge clk_i)
   begin
      phase_q <= phase_d;
   end
endmodule

// ### tb/test_tachometer_measure_postproc.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin fail_count++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module test_tachometer_measure_postproc;
   typedef struct packed {logic [10:0] ctrl; logic s1, s2, red, green, tr, ct;} row_t;
   logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, s1, s2, sw, led, upd;
   logic        red, green, tr, ct, run, pulse;
   logic [7:0]  wb_adr_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic [3:0]  keys, keys_o;
   logic [15:0] rate, freq, measure;
   int          fail_count = 0;
   int          tests_run = 0;
   int          n;
   row_t        rows [12] = '{'{11'h100,1,0,1,0,1,0}, '{11'h104,0,1,0,1,0,1}, '{11'h108,0,0,1,0,0,0},
      '{11'h108,0,1,0,1,0,1}, '{11'h10c,0,0,0,1,0,0}, '{11'h10c,1,0,1,0,1,0}, '{11'h118,0,1,1,0,0,1},
      '{11'h118,1,0,0,1,1,0}, '{11'h11c,0,1,0,1,0,1}, '{11'h11c,1,0,1,0,1,0}, '{11'h140,1,0,1,0,0,1},
      '{11'h140,0,1,1,0,1,0}};
   logic [3:0]  allow [6] = '{4'hf, 4'he, 4'ha, 4'h6, 4'h2, 4'h0};
   logic [7:0]  radr [4] = '{8'h00, 8'h04, 8'h08, 8'h10};
   logic [31:0] rval [4] = '{32'h100, 32'h00a, 32'h000, 32'h000};

   tachometer_measure_postproc #(.SAMPLE_CYCLES(20), .TENTH_CYCLES(10)) tachometer_measure_postproc_inst (
      .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(4'hf),
      .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .inputs_i({1'b0, pulse}), .freq_i(freq), .stage_one_i(s1), .stage_two_i(s2),
      .key_protect_sw_i(sw), .keys_i(keys), .keys_o(keys_o), .key_protect_led_o(led), .measure_o(measure),
      .measure_update_o(upd), .colour_red_o(red), .colour_green_o(green), .transistor_o(tr),
      .contact_o(ct));
   pulse_sensor_model pulse_sensor_model_inst (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .rate_i(rate),
      .pulse_o(pulse), .freq_o(freq));

   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // ----------------------------------------------------------------
   // Bus, wait and closing tasks
   // ----------------------------------------------------------------
   task tick(input int k);
      repeat (k) @(posedge clk_i);
   endtask
   task wb(input logic [7:0] a, input logic [31:0] d, input logic w);
      int k;
      k = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin @(posedge clk_i); k++; end while (wb_ack_o !== 1'b1 && k < 20);
      `CHK("ack", 1'b1, wb_ack_o)
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask
   task wait_upd();
      n = 0;
      do begin @(posedge clk_i); n++; end while (upd !== 1'b1 && n < 400);
      #1;
   endtask
   task print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // The longest path is the eight-sample average; the whole run needs under a thousand cycles.
   initial
   begin
      repeat (20000) @(posedge clk_i);
      fail_count++;
      print_verdict();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      {rst_i, run, s1, s2, sw} = 5'b11000;
      {wb_we_i, wb_cyc_i, wb_stb_i} = 3'b000;
      wb_adr_i = 8'h00;
      wb_dat_i = 32'h0;
      keys = 4'hf;
      rate = 16'h0123;
      tick(20);
      rst_i <= 1'b0;
      foreach (radr[i])
      begin
         wb(radr[i], 32'h0, 1'b0);
         `CHK("reg", rval[i], q)
      end
      $display("test reset done");
      foreach (rows[i])
      begin
         wb(8'h00, {21'h0, rows[i].ctrl}, 1'b1);
         s1 <= rows[i].s1;
         s2 <= rows[i].s2;
         tick(3);
         `CHK("red", rows[i].red, red)
         `CHK("green", rows[i].green, green)
         `CHK("transistor", rows[i].tr, tr)
         `CHK("contact", rows[i].ct, ct)
      end
      $display("test colour table done");
      for (int l = 1; l <= 5; l++)
      begin
         wb(8'h00, {21'h0, l[2:0], 8'h00}, 1'b1);
         sw <= 1'b1;
         tick(2);
         `CHK("keys", allow[l], keys_o)
         `CHK("led", 1'b1, led)
         wb(8'h0c, 32'h0, 1'b0);
         `CHK("switch bit", 1'b1, q[18])
         sw <= 1'b0;
         tick(2);
         `CHK("keys", 4'hf, keys_o)
         `CHK("led", 1'b0, led)
      end
      $display("test key protect done");
      run <= 1'b1;
      wb(8'h00, 32'h100, 1'b1);
      wait_upd();
      wait_upd();
      `CHK("measure", 16'h0123, measure)
      `CHK("period", 20, n)
      // Four samples are asked for, then two after one sample: the stale sample must not count.
      wb(8'h00, 32'h102, 1'b1);
      rate <= 16'h0100;
      tick(20);
      wb(8'h00, 32'h101, 1'b1);
      rate <= 16'h0200;
      wait_upd();
      `CHK("fresh history", 16'h0200, measure)
      tick(25);
      rate <= 16'h0100;
      wait_upd();
      `CHK("two sample mean", 16'h0180, measure)
      wb(8'h00, 32'h103, 1'b1);
      rate <= 16'h0123;
      wait_upd();
      wait_upd();
      `CHK("period", 160, n)
      `CHK("measure", 16'h0123, measure)
      $display("test averaging done");
      wb(8'h04, 32'h0, 1'b1);
      wb(8'h04, 32'h0, 1'b0);
      `CHK("zero clamp", 32'h001, q)
      wb(8'h04, 32'h2, 1'b1);
      run <= 1'b0;
      tick(40);
      `CHK("measure", 16'h0, measure)
      wb(8'h0c, 32'h0, 1'b0);
      `CHK("zero flag", 1'b1, q[16])
      `CHK("pulse level", 1'b0, q[19])
      wb(8'h00, 32'h183, 1'b1);
      tick(2);
      wb(8'h0c, 32'h0, 1'b0);
      `CHK("pulse level", 1'b1, q[19])
      wb(8'h00, 32'h103, 1'b1);
      run <= 1'b1;
      tick(12);
      `CHK("measure", 16'h0123, measure)
      $display("test zero timeout done");
      rst_i <= 1'b1;
      s1 <= 1'b1;
      s2 <= 1'b0;
      tick(2);
      rst_i <= 1'b0;
      wb(8'h08, 32'h5, 1'b1);
      tick(5);
      `CHK("transistor", 1'b0, tr)
      wb(8'h0c, 32'h0, 1'b0);
      `CHK("busy", 1'b1, q[17])
      tick(60);
      `CHK("transistor", 1'b1, tr)
      $display("test startup done");
      print_verdict();
   end
endmodule
